// *** include/dpi_pkg.sv ***
package dpi_pkg;
    // slave address: fixed upper five bits, then the two strap bits
    localparam logic [4:0] ADDR_FIXED = 5'h0B;
    // register addresses inside the instruction byte
    localparam logic [4:0] REG_WIPER_ONE = 5'h01;
    localparam logic [4:0] REG_WIPER_THREE = 5'h03;
    localparam logic [4:0] REG_USER_FIRST = 5'h04;
    localparam logic [4:0] REG_USER_LAST = 5'h0F;
    // instruction byte field positions
    localparam int INS_CMD_BIT = 7;
    localparam int INS_TARGET_BIT = 5;
    // wiper reset value and 64-step mask
    localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
    localparam logic [7:0] WIPER_MASK_64 = 8'h3F;
    localparam logic [7:0] STORE_ERASED = 8'hFF;
    // nonvolatile write cycle and restore times
    localparam int CLK_MHZ = 25;
    localparam int STORE_TIME_MS = 26;
    localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLK_MHZ;
    localparam int RESTORE_TIME_US = 300;
    localparam int RESTORE_CYCLES = RESTORE_TIME_US * CLK_MHZ;
    localparam int NV_DEPTH = 16;

    // byte engine states
    typedef enum logic [2:0] {
        DPI_IDLE = 3'b000,
        DPI_SHIFT = 3'b001,
        DPI_ACK = 3'b010,
        DPI_SEND = 3'b011,
        DPI_RACK = 3'b100
    } dpi_state_e;
endpackage : dpi_pkg

// *** rtl/dpi_port.sv ***
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1 - data sampled on rising clock edges, msb first
// RULE2 - two strap inputs join the slave address decode
// RULE3 - write protect pin is active low
// RULE4 - direction bit high means read, low means write
// RULE5 - instruction bit seven high selects command, low register access
// RULE6 - target bit high selects nonvolatile store, low the wipers
// RULE7 - five-bit register address field in the instruction byte
// RULE8 - wiper addresses 00001 and 00011; others reserved
// RULE9 - 256-step uses eight bits; 64-step ignores two msbs
// RULE10 - consecutive write from 00001 loads wiper one then three
// RULE11 - each wiper has its own nonvolatile location
// RULE12 - single and consecutive writes also work for the store
// RULE13 - twelve user bytes at store locations four to fifteen
// RULE14 - after a store write the port ignores the bus until done
// RULE15 - host polls for acknowledge after each store write
// RULE16 - poll is start, address, write; ack only when cycle done
// RULE17 - write protect blocks all writes, reads keep working
// RULE18 - wipers preset to midscale then restored from the store
// RULE19 - ack only on matching straps; reserved writes ignored
module dpi_port #(
    parameter int STORE_WAIT = dpi_pkg::STORE_CYCLES,
    parameter int RESTORE_WAIT = dpi_pkg::RESTORE_CYCLES,
    parameter bit STEPS_64 = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_low_i,
    input wire logic addr_select_high_i,
    input wire logic write_protect_n_i,
    output logic [7:0] wiper_one_setting_o,
    output logic [7:0] wiper_three_setting_o,
    output logic busy_o
);
    import dpi_pkg::*;

    typedef struct packed {
        dpi_state_e st;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic full;              // eight bits shifted in since the last boundary
        logic [1:0] bytecnt;     // 0 addr, 1 instruction, 2 data
        logic rd;
        logic cmd;
        logic tgt;
        logic [4:0] ptr;
        logic wrote_nv;
        logic [24:0] timer;
        logic restoring;
        logic sda_oe;
        logic [7:0] w1;
        logic [7:0] w3;
        logic scl_d;
        logic sda_d;
        logic busy;
    } dpi_state_s;

    dpi_state_s r, n;
    logic [7:0] nv [NV_DEPTH];
    logic scl_s, sda_s, wp_n_s, a0_s, a1_s;
    logic scl_rise, scl_fall, start_c, stop_c, nv_we;
    logic [7:0] wdata, rdata;

    // all pins cross in through two flip-flops
    dpi_sync u_scl (.clk_i(clk_i), .rst_i(rst_i), .d_i(scl_i), .q_o(scl_s));
    dpi_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .d_i(sda_i), .q_o(sda_s));
    dpi_sync u_wp (.clk_i(clk_i), .rst_i(rst_i), .d_i(write_protect_n_i), .q_o(wp_n_s));
    dpi_sync u_a0 (.clk_i(clk_i), .rst_i(rst_i), .d_i(addr_select_low_i), .q_o(a0_s));
    dpi_sync u_a1 (.clk_i(clk_i), .rst_i(rst_i), .d_i(addr_select_high_i), .q_o(a1_s));

    // bus edge and condition detection
    assign scl_rise = scl_s & ~r.scl_d;  // see RULE1
    assign scl_fall = ~scl_s & r.scl_d;
    assign start_c = scl_s & r.scl_d & r.sda_d & ~sda_s;
    assign stop_c = scl_s & r.scl_d & ~r.sda_d & sda_s;

    // wiper data width per variant
    assign wdata = STEPS_64 ? (r.shreg & WIPER_MASK_64) : r.shreg;  // see RULE9
    assign rdata = r.tgt ? nv[r.ptr[3:0]] : (r.ptr == REG_WIPER_THREE ? r.w3 : r.w1);

    // next-state logic
    always_comb begin
        n = r;
        nv_we = 1'b0;
        n.scl_d = scl_s;
        n.sda_d = sda_s;
        if (r.timer != 25'h0) begin
            n.timer = r.timer - 25'h1;
        end
        // restore wipers from the store once the preset has settled
        if (r.restoring && r.timer == 25'h1) begin
            n.restoring = 1'b0;
            n.w1 = STEPS_64 ? (nv[1] & WIPER_MASK_64) : nv[1];  // see RULE18
            n.w3 = STEPS_64 ? (nv[3] & WIPER_MASK_64) : nv[3];  // see RULE11
        end
        if (r.timer != 25'h0) begin
            // deaf during store write, so no ack reaches the poll
            n.st = DPI_IDLE;  // see RULE14, see RULE16
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st = DPI_IDLE;
            n.sda_oe = 1'b0;
            if (r.wrote_nv) begin
                n.timer = 25'(STORE_WAIT);  // see RULE14
                n.wrote_nv = 1'b0;
            end
        end else if (start_c) begin
            n.st = DPI_SHIFT;
            n.bitcnt = 3'h0;
            n.bytecnt = 2'h0;
            n.full = 1'b0;
            n.sda_oe = 1'b0;
            if (r.wrote_nv) begin
                n.timer = 25'(STORE_WAIT);
                n.wrote_nv = 1'b0;
                n.st = DPI_IDLE;
            end
        end else begin
            unique case (r.st)
                DPI_IDLE: begin
                end
                DPI_SHIFT: begin
                    if (scl_rise) begin
                        n.shreg = {r.shreg[6:0], sda_s};  // see RULE1
                        n.bitcnt = r.bitcnt + 3'h1;
                        n.full = (r.bitcnt == 3'h7);
                    end else if (scl_fall && r.full) begin
                        // the clock fall that ends a start has no bits behind it
                        n.st = DPI_ACK;
                        n.full = 1'b0;
                        if (r.bytecnt == 2'h0) begin
                            // address match with strapped bits
                            if (r.shreg[7:1] == {ADDR_FIXED, a1_s, a0_s}) begin  // see RULE2, see RULE19
                                n.sda_oe = 1'b1;
                                n.rd = r.shreg[0];  // see RULE4
                            end else begin
                                n.st = DPI_IDLE;
                            end
                        end else if (r.bytecnt == 2'h1) begin
                            n.cmd = r.shreg[INS_CMD_BIT];  // see RULE5
                            n.tgt = r.shreg[INS_TARGET_BIT];  // see RULE6
                            n.ptr = r.shreg[4:0];  // see RULE7
                            n.sda_oe = 1'b1;
                        end else begin
                            n.sda_oe = 1'b1;
                            // writes blocked while protected; commands not handled
                            if (wp_n_s && !r.cmd) begin  // see RULE3, see RULE17
                                if (r.tgt) begin
                                    if (r.ptr == REG_WIPER_ONE || r.ptr == REG_WIPER_THREE
                                        || (r.ptr >= REG_USER_FIRST && r.ptr <= REG_USER_LAST)) begin
                                        nv_we = 1'b1;  // see RULE12, see RULE13
                                        n.wrote_nv = 1'b1;
                                    end
                                end else if (r.ptr == REG_WIPER_ONE) begin
                                    n.w1 = wdata;  // see RULE8
                                end else if (r.ptr == REG_WIPER_THREE) begin
                                    n.w3 = wdata;  // see RULE8
                                end
                            end
                            // consecutive write steps 1 to 3 for wipers
                            n.ptr = (!r.tgt && r.ptr == REG_WIPER_ONE) ? REG_WIPER_THREE
                                    : r.ptr + 5'h1;  // see RULE10
                        end
                    end
                end
                DPI_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        if (r.bytecnt == 2'h0 && r.rd) begin
                            n.st = DPI_SEND;
                            n.shreg = rdata;
                            n.sda_oe = ~rdata[7];
                        end else begin
                            n.st = DPI_SHIFT;
                            n.bytecnt = (r.bytecnt == 2'h2) ? 2'h2 : r.bytecnt + 2'h1;
                        end
                    end
                end
                DPI_SEND: begin
                    // reads work regardless of write protect
                    if (scl_fall) begin
                        n.bitcnt = r.bitcnt + 3'h1;
                        if (r.bitcnt == 3'h7) begin
                            n.st = DPI_RACK;
                            n.sda_oe = 1'b0;
                        end else begin
                            n.shreg = {r.shreg[6:0], 1'b0};
                            n.sda_oe = ~r.shreg[6];
                        end
                    end
                end
                DPI_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            n.st = DPI_IDLE;
                        end else begin
                            n.ptr = (!r.tgt && r.ptr == REG_WIPER_ONE) ? REG_WIPER_THREE
                                    : r.ptr + 5'h1;
                        end
                    end else if (scl_fall) begin
                        n.st = DPI_SEND;
                        n.bitcnt = 3'h0;
                        n.shreg = r.tgt ? nv[r.ptr[3:0]]
                                  : (r.ptr == REG_WIPER_THREE ? r.w3 : r.w1);
                        n.sda_oe = 1'b0;
                        if (r.tgt) begin
                            n.sda_oe = ~nv[r.ptr[3:0]][7];
                        end else begin
                            n.sda_oe = ~(r.ptr == REG_WIPER_THREE ? r.w3[7] : r.w1[7]);
                        end
                    end
                end
                default: n.st = DPI_IDLE;
            endcase
        end
        // busy flag registered beside the timer
        n.busy = (n.timer != 25'h0);
    end

    // state register; wipers preset to midscale
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{st: DPI_IDLE, shreg: 8'h00, bitcnt: 3'h0, full: 1'b0, bytecnt: 2'h0, rd: 1'b0,
                   cmd: 1'b0, tgt: 1'b0, ptr: 5'h00, wrote_nv: 1'b0,
                   timer: 25'(RESTORE_WAIT), restoring: 1'b1, sda_oe: 1'b0,
                   w1: WIPER_MIDSCALE, w3: WIPER_MIDSCALE, scl_d: 1'b1,
                   sda_d: 1'b1, busy: 1'b1};  // see RULE18
        end else begin
            r <= n;
        end
    end

    // nonvolatile array, kept over reset
    always_ff @(posedge clk_i) begin
        if (nv_we) begin
            nv[r.ptr[3:0]] <= wdata;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = r.sda_oe;
    assign wiper_one_setting_o = r.w1;
    assign wiper_three_setting_o = r.w3;
    assign busy_o = r.busy;
endmodule : dpi_port
`default_nettype wire

// *** rtl/dpi_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpi_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;
    // two-stage synchroniser, meta read only by q_o
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : dpi_sync
`default_nettype wire

// *** verification/dpi_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpi_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // idle: clock high, data released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    // start or repeated start
    task automatic start_c();
        sda_low_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask : start_c
    task automatic stop_c();
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b0;
        tick(4);
    endtask : stop_c
    // one bit: set mid-low, sampled mid-high
    task automatic bit_c(input logic b, output logic r);
        sda_low_o = !b;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        r = sda_i;
        tick(2);
        scl_o = 1'b0;
        tick(2);
    endtask : bit_c
    task automatic wr(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(b[i], r);
        bit_c(1'b1, r);
        ack = !r;
    endtask : wr
    task automatic rd(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
        bit_c(nack, r);
    endtask : rd
    // address polls until the port answers, 20 tries at most
    task automatic poll(input logic [7:0] adr, output int n);
        logic ack;
        n = 0;
        ack = 1'b0;
        while (!ack && n < 20) begin
            start_c();
            wr(adr, ack);
            stop_c();
            n++;
        end
    endtask : poll
endmodule : dpi_host
`default_nettype wire

// *** verification/dpi_port_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpi_port_properties
    import dpi_pkg::*;
#(
    parameter int STORE_WAIT = 200,
    parameter int RESTORE_WAIT = 50
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic addr_select_low_i,
    input wire logic addr_select_high_i,
    input wire logic write_protect_n_i,
    input wire logic [7:0] wiper_one_setting_o,
    input wire logic [7:0] wiper_three_setting_o,
    input wire logic busy_o
);
    int run;
    bit armed;  // low only before the first clock edge
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // length of the current busy stretch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) run <= 0;
        else run <= busy_o ? run + 1 : 0;
    end
    // state is unknown until the first edge has applied reset
    always_ff @(posedge clk_i) begin
        armed <= 1'b1;
    end
    // reset, restore and store timing
    reset_mid_a: assert property (disable iff (1'b0) armed && rst_i |-> busy_o &&
        wiper_one_setting_o == WIPER_MIDSCALE && wiper_three_setting_o == WIPER_MIDSCALE)
        else $error("wipers not midscale in reset");
    restore_busy_a: assert property ($fell(rst_i) |-> busy_o[*8])
        else $error("busy dropped early after reset");
    busy_min_a: assert property ($fell(busy_o) |-> $past(run) >= RESTORE_WAIT - 2)
        else $error("busy stretch too short");
    busy_max_a: assert property (run <= STORE_WAIT + RESTORE_WAIT + 8)
        else $error("busy stretch too long");
    store_busy_a: assert property ($rose(busy_o) |-> busy_o[*8])
        else $error("store cycle too short");
    // bus behaviour
    busy_quiet_a: assert property (busy_o |-> !sda_oe_o)
        else $error("port answered while busy");
    sda_zero_a: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    ack_edge_a: assert property ($rose(sda_oe_o) |-> $past(!scl_i, 2))
        else $error("data line pulled while clock high");
    wp_freeze_a: assert property (!write_protect_n_i && $past(!write_protect_n_i, 4)
        && !busy_o && $past(!busy_o, 3) |=> $stable(wiper_one_setting_o)
        && $stable(wiper_three_setting_o)) else $error("wiper written while protected");
    cover property ($rose(busy_o));
    cover property ($rose(sda_oe_o));
    cover property ($changed(wiper_three_setting_o));
endmodule : dpi_port_properties
`default_nettype wire

// *** verification/dual_pot_i2c_register_port_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module dual_pot_i2c_register_port_bench;
    import dpi_pkg::*;
    typedef struct packed {
        logic [7:0] ins, d0, d1;
        logic [1:0] n;
        logic [7:0] e1, e3;
    } dpi_row_s;
    localparam logic [7:0] SLV = {ADDR_FIXED, 2'b10, 1'b0};
    dpi_row_s rows [6] = '{'{8'h01, 8'h3C, 8'h5A, 2'd2, 8'h3C, 8'h5A},
        '{8'h03, 8'h77, 8'h00, 2'd1, 8'h3C, 8'h77}, '{8'h00, 8'h11, 8'h00, 2'd1, 8'h3C, 8'h77},
        '{8'h02, 8'h22, 8'h00, 2'd1, 8'h3C, 8'h77}, '{8'h81, 8'h44, 8'h00, 2'd1, 8'h3C, 8'h77},
        '{8'h01, 8'hFF, 8'h00, 2'd1, 8'hFF, 8'h77}};
    logic [15:0] store [3] = '{16'h215A, 16'h236C, 16'h2F9E};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_n = 1'b1;
    logic al = 1'b0;
    logic ah = 1'b1;
    logic scl, host_low, oe, sdo, busy, sda;
    logic [7:0] w1, w3, r;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    // open-drain line with pull-up
    assign sda = !(host_low || (oe && !sdo));
    dpi_host i_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    dpi_port #(.STORE_WAIT(200), .RESTORE_WAIT(50)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .addr_select_low_i(al),
        .addr_select_high_i(ah), .write_protect_n_i(wp_n), .wiper_one_setting_o(w1),
        .wiper_three_setting_o(w3), .busy_o(busy));
    initial begin
        forever #20 clk_i = !clk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // write frame: address, instruction, up to two data bytes
    task automatic put(input logic [7:0] adr, ins, d0, d1, input logic [1:0] n,
        input logic [7:0] exa);
        logic k;
        i_host.start_c();
        i_host.wr(adr, k);
        check({7'h0, k}, exa);
        i_host.wr(ins, k);
        if (n > 0) i_host.wr(d0, k);
        if (n > 1) i_host.wr(d1, k);
        i_host.stop_c();
    endtask : put
    task automatic get(output logic [7:0] d);
        logic k;
        i_host.start_c();
        i_host.wr(SLV | 8'h01, k);
        i_host.rd(d, 1'b1);
        i_host.stop_c();
    endtask : get
    task automatic idle();
        for (int i = 0; i < 400 && busy === 1'b1; i++) @(negedge clk_i);
        check({7'h0, busy}, 8'h00);
    endtask : idle
    // cut a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(negedge clk_i);
        check(w1, WIPER_MIDSCALE);
        check(w3, WIPER_MIDSCALE);
        rst_i = 1'b0;
        idle();
        $display("reset test done");
        foreach (rows[i]) begin
            put(SLV, rows[i].ins, rows[i].d0, rows[i].d1, rows[i].n, 8'h01);
            check(w1, rows[i].e1);
            check(w3, rows[i].e3);
        end
        put(SLV ^ 8'h02, 8'h01, 8'h00, 8'h00, 2'd1, 8'h00);
        put(SLV, 8'h01, 8'h00, 8'h00, 2'd0, 8'h01);
        get(r);
        check(r, 8'hFF);
        wp_n = 1'b0;
        put(SLV, 8'h01, 8'h12, 8'h00, 2'd1, 8'h01);
        check(w1, 8'hFF);
        get(r);
        check(r, 8'h77);
        wp_n = 1'b1;
        $display("edge tests done");
        foreach (store[i]) begin
            put(SLV, store[i][15:8], store[i][7:0], 8'h00, 2'd1, 8'h01);
            i_host.poll(SLV, n);
            check({7'h0, n > 1}, 8'h01);
            check({7'h0, n < 20}, 8'h01);
            check({7'h0, busy}, 8'h00);
        end
        rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        idle();
        put(SLV, 8'h2F, 8'h00, 8'h00, 2'd0, 8'h01);
        get(r);
        check(r, 8'h9E);
        check(w1, 8'h5A);
        check(w3, 8'h6C);
        $display("store tests done");
        end_of_test();
    end
endmodule : dual_pot_i2c_register_port_bench
bind dpi_port dpi_port_properties #(.STORE_WAIT(STORE_WAIT), .RESTORE_WAIT(RESTORE_WAIT))
    i_props (.clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_select_low_i,
    .addr_select_high_i, .write_protect_n_i, .wiper_one_setting_o, .wiper_three_setting_o,
    .busy_o);
`default_nettype wire
